// ---- design/sbc_consts.svh ----
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// Clock and array timing, all in ns
`define SBC_CLK_NS 50
`define SBC_TRP_NS 20
`define SBC_TRC_NS 70
`define SBC_TDPL_NS 10
// Least times round up to whole cycles
`define SBC_CYC(ns) (((ns) + `SBC_CLK_NS - 1) / `SBC_CLK_NS)

// Address field positions
`define SBC_BANK_BIT 11
`define SBC_AUTOCLOSE_BIT 10
`define SBC_MODE_BL_LSB 0
`define SBC_MODE_CL_BIT 4

// Mode register reset values
`define SBC_MODE_RST_BL 3'h3
`define SBC_MODE_RST_CL3 1'b1

`define SBC_FIFO_DEPTH 8

`endif

// ---- design/sbc_pkg.sv ----
package sbc_pkg;

	typedef enum logic [2:0] {
		BS_IDLE = 3'h0,
		BS_ACTIVE = 3'h1,
		BS_READ = 3'h2,
		BS_WRITE = 3'h3,
		BS_READ_AP = 3'h4,
		BS_WRECOV = 3'h5,
		BS_PRECHG = 3'h6,
		BS_REFRESH = 3'h7
	} sbc_bank_state_type;

	typedef enum logic [3:0] {
		CMD_UNSEL = 4'h0,
		CMD_IDLE_CYCLE = 4'h1,
		CMD_HALT_BURST = 4'h2,
		CMD_FETCH = 4'h3,
		CMD_STORE = 4'h4,
		CMD_OPEN_ROW = 4'h5,
		CMD_CLOSE = 4'h6,
		CMD_RENEW = 4'h7,
		CMD_LOAD_SETTINGS = 4'h8
	} sbc_cmd_type;

endpackage

// ---- design/sbc_cmd_decode.sv ----
`timescale 1ns/1ps
module sbc_cmd_decode import sbc_pkg::*; (
	// Strobes
	input wire logic chipSelN,
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic writeEnN,
	// Decoded command
	output sbc_cmd_type cmd
);
	always_comb begin
		cmd = CMD_UNSEL;
		if (!chipSelN) begin
			unique case ({rowStrobeN, colStrobeN, writeEnN})
				3'h7: cmd = CMD_IDLE_CYCLE;
				3'h6: cmd = CMD_HALT_BURST;
				3'h5: cmd = CMD_FETCH;
				3'h4: cmd = CMD_STORE;
				3'h3: cmd = CMD_OPEN_ROW;
				3'h2: cmd = CMD_CLOSE;
				3'h1: cmd = CMD_RENEW;
				3'h0: cmd = CMD_LOAD_SETTINGS;
			endcase
		end
	end
endmodule // sbc_cmd_decode

// ---- design/sbc_fifo.sv ----
`timescale 1ns/1ps
module sbc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("sbc_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign inReady = count_r != (AW+1)'(DEPTH);
	assign outValid = count_r != '0;
	assign outData = mem_r[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // sbc_fifo

// ---- design/sbc_bank_fsm.sv ----
// How it works
// - Idle ignores deselect, idle and halt; a gate drop powers down.
// - Deselect or idle in a read let it finish, then row active.
// - Halt in a read cuts it short and leaves the row open.
// - A read in a read ends it and restarts at the new column.
// - A store in a read ends it and starts a write at the new column.
// - A close in a read ends it and precharges the bank or banks.
// - Deselect or idle in a write let it finish, then write recovery.
// - Halt in a write stops it and leaves the bank row active.
// - A read in a write ends it and starts a read at the new column.
// - A store in a write ends it and restarts at the new column.
// - A close in a write ends it and precharges the bank or banks.
// - Auto-precharge reads run on, then precharge; all else but deselect, idle, or an open or a close of the other bank is illegal.
// - After a halt in a read, data runs on for the column latency.
// - Gate low powers down; while it was low on the previous edge, every other input but reset and rdReady is ignored.
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_bank_fsm import sbc_pkg::*; #(
	parameter int DATA_W = 16,
	parameter int COL_BITS = 8,
	parameter int FIFO_DEPTH = `SBC_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command pins
	input wire logic clockGate,
	input wire logic chipSelN,
	input wire logic rowStrobeN,
	input wire logic colStrobeN,
	input wire logic writeEnN,
	input wire logic [11:0] addr,
	// Write data, taken with each write beat
	input wire logic [DATA_W-1:0] wrData,
	// Read data stream
	output logic rdValid,
	input wire logic rdReady,
	output logic [DATA_W-1:0] rdData,
	output logic rdRoomOk,
	// Status
	output sbc_bank_state_type bank0State,
	output sbc_bank_state_type bank1State,
	output logic powerDown,
	output logic illegalCmd,
	output logic rdOverrun
);
	localparam int NB = 2;
	localparam logic [2:0] TRP_CYC = 3'(`SBC_CYC(`SBC_TRP_NS) - 1);
	localparam logic [2:0] TRC_CYC = 3'(`SBC_CYC(`SBC_TRC_NS) - 1);
	localparam logic [2:0] TDPL_CYC = 3'(`SBC_CYC(`SBC_TDPL_NS) - 1);

	if (COL_BITS < 3 || COL_BITS > 10 || DATA_W < 1) begin : g_chk
		$error("sbc_bank_fsm: COL_BITS must be 3..10");
	end

	// Burst length code to beats; codes above 3 run a full page
	function automatic logic [COL_BITS:0] beats(input logic [2:0] code);
		beats = (code > 3'h3) ? (COL_BITS+1)'(1 << COL_BITS) :
			(COL_BITS+1)'(1 << code);
	endfunction

	sbc_cmd_type cmd;
	sbc_bank_state_type bankState_r [NB];
	logic [2:0] timer_r [NB];
	logic ckePrev_r;
	logic powerDown_r;
	logic illegal_r;
	logic overrun_r;
	logic [2:0] modeBl_r;
	logic modeCl3_r;
	logic burstActive_r;
	logic burstWrite_r;
	logic burstBank_r;
	logic [COL_BITS-1:0] burstCol_r;
	logic [COL_BITS:0] burstLeft_r;
	logic [DATA_W-1:0] mem_r [2**(COL_BITS+1)];
	logic [2:0] pipeValid_r;
	logic [DATA_W-1:0] pipeData_r [3];

	logic run;
	logic cmdBank;
	logic autoClose;
	logic [COL_BITS-1:0] column;
	sbc_bank_state_type tgt;
	logic bothIdle;
	logic ownerAp;
	logic illegal;
	logic take;
	logic colCmd;
	logic start;
	logic stopBurst;
	logic lastBeat;
	logic beat;
	logic beatWrite;
	logic [COL_BITS:0] beatAddr;
	logic [COL_BITS:0] startBeats;
	logic fifoInValid;
	logic fifoInReady;
	logic [DATA_W-1:0] fifoInData;

	sbc_cmd_decode u_dec (
		.chipSelN(chipSelN),
		.rowStrobeN(rowStrobeN),
		.colStrobeN(colStrobeN),
		.writeEnN(writeEnN),
		.cmd(cmd)
	);

	// Commands count only when the gate was high on the previous edge
	assign run = ckePrev_r;
	assign cmdBank = addr[`SBC_BANK_BIT];
	assign autoClose = addr[`SBC_AUTOCLOSE_BIT];
	assign column = addr[COL_BITS-1:0];
	assign tgt = bankState_r[cmdBank];
	assign bothIdle = bankState_r[0] == BS_IDLE &&
		bankState_r[1] == BS_IDLE;
	assign ownerAp = burstActive_r &&
		bankState_r[burstBank_r] == BS_READ_AP;
	assign colCmd = cmd == CMD_FETCH || cmd == CMD_STORE;

	// Illegal commands are flagged and otherwise ignored
	always_comb begin
		illegal = 1'b0;
		unique case (cmd)
			CMD_UNSEL, CMD_IDLE_CYCLE: illegal = 1'b0;
			CMD_HALT_BURST: illegal = ownerAp || tgt == BS_READ_AP;
			CMD_FETCH, CMD_STORE: illegal = ownerAp ||
				!(tgt == BS_ACTIVE || tgt == BS_READ ||
				tgt == BS_WRITE || tgt == BS_WRECOV);
			CMD_OPEN_ROW: illegal = tgt != BS_IDLE;
			CMD_CLOSE: illegal = autoClose ? (bankState_r[0] == BS_READ_AP ||
				bankState_r[1] == BS_READ_AP) : tgt == BS_READ_AP;
			CMD_RENEW, CMD_LOAD_SETTINGS: illegal = !bothIdle;
		endcase
	end

	assign take = run && !illegal;
	assign start = take && colCmd;
	assign startBeats = beats(modeBl_r);
	// Halt or a close that reaches the owner ends the burst at once
	assign stopBurst = take && burstActive_r && (cmd == CMD_HALT_BURST ||
		(cmd == CMD_CLOSE && (autoClose || cmdBank == burstBank_r)));
	assign lastBeat = run && burstActive_r && !start && !stopBurst &&
		burstLeft_r == (COL_BITS+1)'(1);
	assign beat = start || (run && burstActive_r && !stopBurst);
	assign beatWrite = start ? cmd == CMD_STORE : burstWrite_r;
	assign beatAddr = start ? {cmdBank, column} : {burstBank_r, burstCol_r};

	always_ff @(posedge clk) begin
		if (rst) begin
			ckePrev_r <= 1'b0;
			powerDown_r <= 1'b0;
		end else begin
			ckePrev_r <= clockGate;
			if (ckePrev_r && !clockGate) begin
				powerDown_r <= 1'b1;
			end else if (clockGate) begin
				powerDown_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			illegal_r <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			illegal_r <= run && illegal;
			overrun_r <= fifoInValid && !fifoInReady;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			modeBl_r <= `SBC_MODE_RST_BL;
			modeCl3_r <= `SBC_MODE_RST_CL3;
		end else if (take && cmd == CMD_LOAD_SETTINGS) begin
			modeBl_r <= addr[`SBC_MODE_BL_LSB +: 3];
			modeCl3_r <= addr[`SBC_MODE_CL_BIT];
		end
	end

	// Per-bank state; the burst owner follows the shared burst engine
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int b = 0; b < NB; b++) begin
				bankState_r[b] <= BS_IDLE;
				timer_r[b] <= '0;
			end
		end else if (run) begin
			for (int b = 0; b < NB; b++) begin
				if (timer_r[b] != '0) begin
					timer_r[b] <= timer_r[b] - 1'b1;
				end else if (bankState_r[b] == BS_PRECHG ||
					bankState_r[b] == BS_REFRESH) begin
					bankState_r[b] <= BS_IDLE;
				end else if (bankState_r[b] == BS_WRECOV) begin
					bankState_r[b] <= BS_ACTIVE;
				end
				if (take && cmd == CMD_OPEN_ROW && cmdBank == 1'(b)) begin
					bankState_r[b] <= BS_ACTIVE;
				end else if (take && cmd == CMD_RENEW) begin
					bankState_r[b] <= BS_REFRESH;
					timer_r[b] <= TRC_CYC;
				end else if (start && cmdBank == 1'(b)) begin
					timer_r[b] <= '0;
					if (startBeats == (COL_BITS+1)'(1)) begin
						bankState_r[b] <= cmd == CMD_STORE ? BS_WRECOV :
							autoClose ? BS_PRECHG : BS_ACTIVE;
						timer_r[b] <= cmd == CMD_STORE ? TDPL_CYC : TRP_CYC;
					end else if (cmd == CMD_STORE) begin
						bankState_r[b] <= BS_WRITE;
					end else begin
						bankState_r[b] <= autoClose ? BS_READ_AP : BS_READ;
					end
				end else if (take && cmd == CMD_CLOSE &&
					(autoClose || cmdBank == 1'(b))) begin
					if (bankState_r[b] != BS_IDLE &&
						bankState_r[b] != BS_REFRESH) begin
						bankState_r[b] <= BS_PRECHG;
						timer_r[b] <= TRP_CYC;
					end
				end else if (burstActive_r && burstBank_r == 1'(b) &&
					(start || stopBurst)) begin
					bankState_r[b] <= BS_ACTIVE;
				end else if (lastBeat && burstBank_r == 1'(b)) begin
					unique case (bankState_r[b])
						BS_READ: bankState_r[b] <= BS_ACTIVE;
						BS_WRITE: begin
							bankState_r[b] <= BS_WRECOV;
							timer_r[b] <= TDPL_CYC;
						end
						BS_READ_AP: begin
							bankState_r[b] <= BS_PRECHG;
							timer_r[b] <= TRP_CYC;
						end
						default: bankState_r[b] <= bankState_r[b];
					endcase
				end
			end
		end
	end

	// Shared burst engine: first beat on the command edge
	always_ff @(posedge clk) begin
		if (rst) begin
			burstActive_r <= 1'b0;
			burstWrite_r <= 1'b0;
			burstBank_r <= 1'b0;
			burstCol_r <= '0;
			burstLeft_r <= '0;
		end else if (start) begin
			burstActive_r <= startBeats != (COL_BITS+1)'(1);
			burstWrite_r <= cmd == CMD_STORE;
			burstBank_r <= cmdBank;
			burstCol_r <= column + 1'b1;
			burstLeft_r <= startBeats - 1'b1;
		end else if (stopBurst || lastBeat) begin
			burstActive_r <= 1'b0;
		end else if (beat) begin
			burstCol_r <= burstCol_r + 1'b1;
			burstLeft_r <= burstLeft_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (beat && beatWrite) begin
			mem_r[beatAddr] <= wrData;
		end
	end

	// Read pipe; a halt stops new loads but words in flight still leave
	always_ff @(posedge clk) begin
		if (rst) begin
			pipeValid_r <= '0;
		end else if (run) begin
			pipeValid_r <= {pipeValid_r[1:0], beat && !beatWrite};
		end
	end

	always_ff @(posedge clk) begin
		if (run) begin
			pipeData_r[0] <= mem_r[beatAddr];
			pipeData_r[1] <= pipeData_r[0];
			pipeData_r[2] <= pipeData_r[1];
		end
	end

	assign fifoInValid = run && (modeCl3_r ? pipeValid_r[2] : pipeValid_r[1]);
	assign fifoInData = modeCl3_r ? pipeData_r[2] : pipeData_r[1];

	sbc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData(rdData)
	);

	assign rdRoomOk = fifoInReady;
	assign bank0State = bankState_r[0];
	assign bank1State = bankState_r[1];
	assign powerDown = powerDown_r;
	assign illegalCmd = illegal_r;
	assign rdOverrun = overrun_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	power_down_a: assert property (
		ckePrev_r && !clockGate |=> powerDown_r until clockGate)
		else $error("power-down not held while gate low");
	suspend_hold_a: assert property (
		!ckePrev_r |=> $stable(bankState_r[0]) && $stable(burstCol_r))
		else $error("state moved during power-down");
	read_end_a: assert property (
		lastBeat && bankState_r[burstBank_r] == BS_READ
		|=> bankState_r[$past(burstBank_r)] == BS_ACTIVE)
		else $error("read burst did not return to row active");
	read_halt_a: assert property (
		take && cmd == CMD_HALT_BURST && burstActive_r && !burstWrite_r
		|=> !burstActive_r && bankState_r[$past(burstBank_r)] == BS_ACTIVE)
		else $error("halt did not end read burst");
	new_read_a: assert property (
		start && cmd == CMD_FETCH && !autoClose && startBeats > 1
		|=> burstActive_r && !burstWrite_r &&
		burstCol_r == COL_BITS'($past(column) + 1'b1))
		else $error("read burst did not restart at new column");
	read_to_write_a: assert property (
		start && cmd == CMD_STORE && startBeats > 1
		|=> burstWrite_r ##0 bankState_r[burstBank_r] == BS_WRITE)
		else $error("store did not start write burst");
	close_read_a: assert property (
		take && cmd == CMD_CLOSE && !autoClose && tgt == BS_READ
		|=> bankState_r[$past(cmdBank)] == BS_PRECHG)
		else $error("close did not start precharge");
	write_recov_a: assert property (
		lastBeat && bankState_r[burstBank_r] == BS_WRITE
		|=> bankState_r[$past(burstBank_r)] == BS_WRECOV)
		else $error("write burst did not enter recovery");
	autoclose_a: assert property (
		lastBeat && bankState_r[burstBank_r] == BS_READ_AP
		|=> bankState_r[$past(burstBank_r)] == BS_PRECHG)
		else $error("auto-precharge did not follow read");
	halt_latency_a: assert property (
		take && cmd == CMD_HALT_BURST && !burstWrite_r && modeCl3_r &&
		pipeValid_r[0] ##1 run ##1 run |-> fifoInValid)
		else $error("read data dropped before latency");

	read_burst_c: cover property (start && cmd == CMD_FETCH ##[1:8] lastBeat);
	write_halt_c: cover property (burstWrite_r && stopBurst);
	power_down_c: cover property (ckePrev_r && !clockGate ##1 !clockGate);
endmodule // sbc_bank_fsm

// ---- test/sbc_ctrl_model.sv ----
`timescale 1ns/1ps
module sbc_ctrl_model import sbc_pkg::*; (
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire sbc_cmd_type cmd,
	input wire logic sinkStall,
	// Command strobes
	output logic chipSelN,
	output logic rowStrobeN,
	output logic colStrobeN,
	output logic writeEnN,
	// Read stream sink
	output logic rdReady
);
	logic junk_r = 1'b0;

	// Unselected strobes wander so no stale level is trusted
	always_ff @(posedge clk) begin
		junk_r <= ~junk_r;
	end

	// Illegal codes are sent only when a refusal is wanted
	always_comb begin
		case (cmd)
		CMD_IDLE_CYCLE: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h7;
		CMD_HALT_BURST: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h6;
		CMD_FETCH: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h5;
		CMD_STORE: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h4;
		CMD_OPEN_ROW: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h3;
		CMD_CLOSE: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h2;
		CMD_RENEW: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h1;
		CMD_LOAD_SETTINGS: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h0;
		default: {chipSelN, rowStrobeN, colStrobeN, writeEnN} =
			{1'b1, junk_r, ~junk_r, junk_r};
		endcase
	end

	assign rdReady = ~sinkStall;
endmodule // sbc_ctrl_model

// ---- test/sbc_bank_fsm_tb.sv ----
`timescale 1ns/1ps
module sbc_bank_fsm_tb import sbc_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clockGate = 1'b1;
	sbc_cmd_type cmd = CMD_UNSEL;
	logic sinkStall = 1'b0;
	logic stallOn = 1'b0;
	logic stallAll = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wrData = 16'h0000;
	logic chipSelN, rowStrobeN, colStrobeN, writeEnN, rdReady;
	logic rdValid, rdRoomOk, powerDown, illegalCmd, rdOverrun;
	logic [15:0] rdData;
	sbc_bank_state_type bank0State, bank1State;
	int num_errors = 0;
	int checked = 0;
	int illCnt = 0;
	int ovrCnt = 0;
	logic [31:0] seed = 32'heb16bfc5;
	logic [15:0] rxq[$];
	logic [15:0] wq[$];
	sbc_cmd_type quiet[4] = '{CMD_UNSEL, CMD_IDLE_CYCLE, CMD_HALT_BURST,
		CMD_CLOSE};
	sbc_cmd_type firsts[2] = '{CMD_FETCH, CMD_STORE};
	sbc_cmd_type seconds[4] = '{CMD_HALT_BURST, CMD_FETCH, CMD_STORE,
		CMD_CLOSE};

	always #25 clk = ~clk;

	sbc_ctrl_model ctrl_u (.clk(clk), .cmd(cmd), .sinkStall(sinkStall),
		.chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
		.colStrobeN(colStrobeN), .writeEnN(writeEnN), .rdReady(rdReady));

	sbc_bank_fsm dut_u (.clk(clk), .rst(rst), .clockGate(clockGate),
		.chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
		.colStrobeN(colStrobeN), .writeEnN(writeEnN), .addr(addr),
		.wrData(wrData), .rdValid(rdValid), .rdReady(rdReady),
		.rdData(rdData), .rdRoomOk(rdRoomOk), .bank0State(bank0State),
		.bank1State(bank1State), .powerDown(powerDown),
		.illegalCmd(illegalCmd), .rdOverrun(rdOverrun));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction

	function automatic sbc_bank_state_type exp_after(input sbc_cmd_type c);
		case (c)
		CMD_HALT_BURST: return BS_ACTIVE;
		CMD_FETCH: return BS_READ;
		CMD_STORE: return BS_WRITE;
		default: return BS_PRECHG;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s seen %0h expected %0h",
				$time, msg, seen, exp);
		end
	endtask

	// Drives one command just after an edge; returns after it is taken
	task automatic step(input sbc_cmd_type c, input logic [11:0] a);
		seed = lfsr_next(seed);
		cmd = c;
		addr = a;
		wrData = seed[15:0];
		sinkStall = stallAll | (stallOn & seed[20]);
		@(posedge clk);
		#1;
	endtask

	task automatic idle(input int n);
		repeat (n) step(CMD_IDLE_CYCLE, 12'h000);
	endtask

	task automatic end_of_test();
		$display("num_errors %0d checked %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		if (rdValid === 1'b1 && rdReady === 1'b1)
			rxq.push_back(rdData);
		if (illegalCmd === 1'b1)
			illCnt++;
		if (rdOverrun === 1'b1)
			ovrCnt++;
	end

	// Whole sequence needs well under 2000 cycles
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end

	initial begin
		logic [7:0] col;
		sbc_bank_state_type want;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
		chk(bank0State, BS_IDLE, "reset state");
		foreach (quiet[i]) begin
			step(quiet[i], 12'h000);
			chk(bank0State, BS_IDLE, "idle quiet");
		end
		chk(illCnt, 0, "idle refusals");
		// Burst code 2 is four beats, latency 3
		step(CMD_LOAD_SETTINGS, 12'h012);
		idle(2);
		step(CMD_RENEW, 12'h000);
		chk(bank0State, BS_REFRESH, "refresh");
		idle(3);
		chk(bank0State, BS_IDLE, "after refresh");
		step(CMD_OPEN_ROW, 12'h800);
		chk(bank1State, BS_ACTIVE, "bank1 open");
		chk(bank0State, BS_IDLE, "bank0 untouched");
		step(CMD_CLOSE, 12'h400);
		chk(bank1State, BS_PRECHG, "close both");
		idle(2);
		chk(bank1State, BS_IDLE, "bank1 idle");
		clockGate = 1'b0;
		idle(1);
		step(CMD_OPEN_ROW, 12'h000);
		step(CMD_OPEN_ROW, 12'h000);
		chk(powerDown, 1'b1, "power-down");
		chk(bank0State, BS_IDLE, "ignored in power-down");
		clockGate = 1'b1;
		idle(2);
		chk(powerDown, 1'b0, "power-down exit");
		step(CMD_OPEN_ROW, 12'h000);
		idle(1);
		chk(bank0State, BS_ACTIVE, "bank0 open");
		col = seed[7:0];
		stallOn = 1'b1;
		step(CMD_STORE, {4'h0, col});
		wq.push_back(wrData);
		chk(bank0State, BS_WRITE, "write start");
		repeat (3) begin
			idle(1);
			wq.push_back(wrData);
		end
		chk(bank0State, BS_WRECOV, "write recovery");
		idle(1);
		chk(bank0State, BS_ACTIVE, "after recovery");
		rxq.delete();
		step(CMD_FETCH, {4'h0, col});
		chk(bank0State, BS_READ, "read start");
		idle(3);
		chk(bank0State, BS_ACTIVE, "read done");
		idle(12);
		stallOn = 1'b0;
		idle(4);
		chk(rxq.size(), 4, "read words");
		for (int i = 0; i < 4; i++)
			chk(rxq[i], wq[i], "read data");
		foreach (firsts[f]) begin
			foreach (seconds[s]) begin
				rxq.delete();
				step(firsts[f], {4'h0, seed[7:0]});
				step(seconds[s], {4'h0, seed[7:0]});
				want = exp_after(seconds[s]);
				if (f == 0)
					chk(bank0State, want, "rd cut");
				else
					chk(bank0State, want, "wr cut");
				idle(8);
				// Halt edge loads no beat, so one word is in flight
				if (f == 0 && s == 0)
					chk(rxq.size(), 1, "words after halt");
				step(CMD_CLOSE, 12'h400);
				idle(2);
				step(CMD_OPEN_ROW, 12'h000);
				idle(1);
			end
		end
		step(CMD_FETCH, 12'h405);
		chk(bank0State, BS_READ_AP, "autoclose read");
		step(CMD_HALT_BURST, 12'h000);
		chk(bank0State, BS_READ_AP, "halt refused");
		idle(5);
		chk(bank0State, BS_IDLE, "autoclose done");
		chk(illCnt, 1, "halt flagged");
		step(CMD_FETCH, 12'h800);
		idle(2);
		chk(bank1State, BS_IDLE, "read on idle bank");
		chk(illCnt, 2, "idle read flagged");
		chk(ovrCnt, 0, "no overrun");
		// Twelve words into a stalled eight-deep buffer
		stallAll = 1'b1;
		step(CMD_OPEN_ROW, 12'h000);
		for (int i = 0; i < 3; i++) begin
			step(CMD_FETCH, 12'(4 * i));
			idle(3);
		end
		idle(4);
		chk(rdRoomOk, 1'b0, "fifo full");
		chk(ovrCnt, 4, "words lost when full");
		rxq.delete();
		stallAll = 1'b0;
		idle(10);
		chk(rxq.size(), 8, "words kept when full");
		chk(rdRoomOk, 1'b1, "fifo drained");
		// Single beat bursts at latency 2
		step(CMD_CLOSE, 12'h400);
		idle(2);
		step(CMD_LOAD_SETTINGS, 12'h000);
		step(CMD_OPEN_ROW, 12'h000);
		step(CMD_STORE, 12'h033);
		wq.push_back(wrData);
		chk(bank0State, BS_WRECOV, "single write");
		idle(1);
		chk(bank0State, BS_ACTIVE, "single recovery");
		rxq.delete();
		step(CMD_FETCH, 12'h033);
		chk(bank0State, BS_ACTIVE, "single read");
		idle(4);
		chk(rxq.size(), 1, "single read words");
		chk(rxq[0], wq[4], "single read data");
		end_of_test();
	end
endmodule // sbc_bank_fsm_tb
